// [hdl/pol_sequencer.sv]
`timescale 1ns/10ps
`include "pol_params.svh"
module pol_sequencer #(
   parameter int RELEASE_CYC = `POL_RELEASE_DELAY_US * `POL_CLK_MHZ,
   parameter int ENGAGE_CYC = `POL_ENGAGE_DELAY_US * `POL_CLK_MHZ,
   parameter int LOCKOUT_REL_CYC = `POL_LOCKOUT_RELEASE_US * `POL_CLK_MHZ,
   parameter int WINDOW_CYC = `POL_UNLOCK_WINDOW_CYC,
   parameter logic [`POL_DATA_W-1:0] UNLOCK_CODE = `POL_UNLOCK_CODE
) (
   clock, // System clock, 125 MHz
   rst_b, // Async reset, active low
   above_reset_rise, // Supply above reset rise threshold
   above_reset_fall, // Supply above reset fall threshold
   above_supply_low, // Supply above low threshold
   above_supply_recover, // Supply above recover threshold
   req, // Register request from controller
   perm_lock_nv, // Stored permanent lock bit
   internal_reset, // Internal reset asserted
   out_enable, // Output driven, not high-z
   out_force_low, // Output pulled to ground
   access_open, // Register access unlocked
   rd_valid, // Read data valid, one cycle
   rd_data, // Read data
   perm_lock_set, // Request to store permanent lock
   trim // Gain and zero-level settings
);
   input wire logic clock;
   input wire logic rst_b;
   input wire logic above_reset_rise;
   input wire logic above_reset_fall;
   input wire logic above_supply_low;
   input wire logic above_supply_recover;
   input wire pol_pkg::pol_req_t req;
   input wire logic perm_lock_nv;
   output logic internal_reset;
   output logic out_enable;
   output logic out_force_low;
   output logic access_open;
   output logic rd_valid;
   output logic [`POL_DATA_W-1:0] rd_data;
   output logic perm_lock_set;
   output pol_pkg::pol_trim_t trim;

   pol_pkg::pol_state_t state_reg;
   pol_pkg::pol_state_t state_next;
   logic release_done;
   logic engage_done;
   logic unlock_done;
   logic window_done;
   logic perm_latched_reg;
   logic window_open_reg;
   logic unlock_hit;
   logic [`POL_CNT_W-1:0] window_count_reg;

   // Release counter runs from reset rise onward
   pol_delay_cnt #(.LIMIT(RELEASE_CYC[`POL_CNT_W-1:0])) u_release (
      .clock(clock),
      .rst_b(rst_b),
      .run(state_reg == pol_pkg::POL_WAIT_RISE),
      .done(release_done)
   );

   pol_delay_cnt #(.LIMIT(ENGAGE_CYC[`POL_CNT_W-1:0])) u_engage (
      .clock(clock),
      .rst_b(rst_b),
      // Drops out once the supply is back above the low threshold, so a short dip never locks out
      .run(state_reg == pol_pkg::POL_NORMAL && !above_supply_low),
      .done(engage_done)
   );

   pol_delay_cnt #(.LIMIT(LOCKOUT_REL_CYC[`POL_CNT_W-1:0])) u_unlock (
      .clock(clock),
      .rst_b(rst_b),
      .run(state_reg == pol_pkg::POL_LOCKOUT && above_supply_recover),
      .done(unlock_done)
   );

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         pol_pkg::POL_RESET:
            if (above_reset_rise)
               state_next = pol_pkg::POL_WAIT_RISE;
         pol_pkg::POL_WAIT_RISE:
            if (!above_reset_fall)
               state_next = pol_pkg::POL_RESET;
            else if (release_done && above_supply_recover)
               state_next = pol_pkg::POL_NORMAL;
         pol_pkg::POL_NORMAL:
            if (!above_reset_fall)
               state_next = pol_pkg::POL_RESET;
            else if (engage_done)
               state_next = pol_pkg::POL_LOCKOUT;
         pol_pkg::POL_LOCKOUT:
            if (!above_reset_fall)
               state_next = pol_pkg::POL_RESET;
            else if (unlock_done)
               state_next = pol_pkg::POL_NORMAL;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         state_reg <= pol_pkg::POL_RESET;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         internal_reset <= 1'b1;
         out_enable <= 1'b0;
         out_force_low <= 1'b0;
      end
      else
      begin
         internal_reset <= state_next == pol_pkg::POL_RESET ||
            state_next == pol_pkg::POL_WAIT_RISE;
         out_enable <= state_next == pol_pkg::POL_NORMAL ||
            state_next == pol_pkg::POL_LOCKOUT;
         out_force_low <= state_next == pol_pkg::POL_LOCKOUT;
      end
   end

   // Window timer restarts on every internal reset, i.e. power cycle
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         window_count_reg <= '0;
      else if (state_reg == pol_pkg::POL_RESET)
         window_count_reg <= '0;
      else if (!window_done)
         window_count_reg <= window_count_reg + 24'h000001;
   end

   assign window_done = window_count_reg >= WINDOW_CYC[`POL_CNT_W-1:0];

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         window_open_reg <= 1'b0;
      else
         window_open_reg <= state_reg != pol_pkg::POL_RESET && !window_done;
   end

   // Permanent lock sampled at each power-up, not mid-session
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         perm_latched_reg <= 1'b0;
      else if (state_reg == pol_pkg::POL_RESET)
         perm_latched_reg <= perm_lock_nv;
   end

   assign unlock_hit = req.wr && req.addr == `POL_UNLOCK_ADDR &&
      req.wdata == UNLOCK_CODE;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         access_open <= 1'b0;
      // Clear on the entry edge, so a drop below the reset fall threshold never leaves access open
      else if (state_next == pol_pkg::POL_RESET)
         access_open <= 1'b0;
      else if (unlock_hit && window_open_reg && !perm_latched_reg)
         access_open <= 1'b1;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         trim.coarse_gain <= `POL_COARSE_RST;
         trim.fine_gain <= `POL_FINE_RST;
         trim.zero_field_level_trim <= `POL_ZERO_RST;
         perm_lock_set <= 1'b0;
      end
      else if (req.wr && access_open && !perm_latched_reg)
      begin
         unique case (req.addr)
            `POL_ADDR_COARSE:
               trim.coarse_gain <= req.wdata[`POL_COARSE_W-1:0];
            `POL_ADDR_FINE:
               trim.fine_gain <= req.wdata[`POL_FINE_W-1:0];
            `POL_ADDR_ZERO:
               trim.zero_field_level_trim <= req.wdata[`POL_ZERO_W-1:0];
            // Set only; no path writes it back to zero
            `POL_ADDR_PLOCK:
               perm_lock_set <= perm_lock_set | req.wdata[0];
            default:
               perm_lock_set <= perm_lock_set;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_valid <= 1'b0;
         rd_data <= '0;
      end
      else
      begin
         rd_valid <= req.rd && access_open && !perm_latched_reg;
         unique case (req.addr)
            `POL_ADDR_COARSE:
               rd_data <= 30'(trim.coarse_gain);
            `POL_ADDR_FINE:
               rd_data <= 30'(trim.fine_gain);
            `POL_ADDR_ZERO:
               rd_data <= 30'(trim.zero_field_level_trim);
            `POL_ADDR_PLOCK:
               rd_data <= 30'(perm_lock_set | perm_lock_nv);
            default:
               rd_data <= '0;
         endcase
      end
   end
endmodule : pol_sequencer

// [hdl/pol_params.svh]
`ifndef POL_PARAMS_SVH
`define POL_PARAMS_SVH

`define POL_ADDR_W 6
`define POL_DATA_W 30
`define POL_UNLOCK_ADDR 6'h24
`define POL_UNLOCK_CODE 30'h2a5c3e17
`define POL_ADDR_COARSE 6'h20
`define POL_ADDR_FINE 6'h21
`define POL_ADDR_ZERO 6'h22
`define POL_ADDR_PLOCK 6'h23
`define POL_COARSE_W 3
`define POL_FINE_W 9
`define POL_ZERO_W 9
`define POL_COARSE_RST 3'h2
`define POL_FINE_RST 9'h000
`define POL_ZERO_RST 9'h000
`define POL_CLK_MHZ 125
`define POL_UNLOCK_WINDOW_MS 8
`define POL_UNLOCK_WINDOW_CYC (`POL_UNLOCK_WINDOW_MS * 1000 * `POL_CLK_MHZ)
`define POL_RELEASE_DELAY_US 64
`define POL_ENGAGE_DELAY_US 64
`define POL_LOCKOUT_RELEASE_US 64
`define POL_CNT_W 24

`endif

// [hdl/pol_pkg.sv]
`include "pol_params.svh"
package pol_pkg;
   typedef enum logic [1:0] {
      POL_RESET = 2'b00,
      POL_WAIT_RISE = 2'b01,
      POL_NORMAL = 2'b10,
      POL_LOCKOUT = 2'b11
   } pol_state_t;

   typedef struct packed {
      logic [`POL_COARSE_W-1:0] coarse_gain;
      logic [`POL_FINE_W-1:0] fine_gain;
      logic [`POL_ZERO_W-1:0] zero_field_level_trim;
   } pol_trim_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [`POL_ADDR_W-1:0] addr;
      logic [`POL_DATA_W-1:0] wdata;
   } pol_req_t;
endpackage : pol_pkg

// [hdl/pol_delay_cnt.sv]
`timescale 1ns/10ps
`include "pol_params.svh"
module pol_delay_cnt #(
   parameter logic [`POL_CNT_W-1:0] LIMIT = 24'h000001
) (
   clock, // System clock
   rst_b, // Async reset, active low
   run, // Count while high, clear when low
   done // Limit reached, held while run
);
   input wire logic clock;
   input wire logic rst_b;
   input wire logic run;
   output logic done;

   logic [`POL_CNT_W-1:0] count_reg;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_reg <= '0;
         done <= 1'b0;
      end
      else if (!run)
      begin
         count_reg <= '0;
         done <= 1'b0;
      end
      else
      begin
         if (count_reg != LIMIT)
            count_reg <= count_reg + 24'h000001;
         done <= (count_reg + 24'h000001 >= LIMIT);
      end
   end
endmodule : pol_delay_cnt

// [sim/pol_supply_model.sv]
`timescale 1ns/10ps
module pol_supply_model (
   input wire logic [2:0] level, // Supply step, 0 is off
   input wire logic perm_lock_set, // Store lock request
   output logic above_reset_fall, // Flag
   output logic above_reset_rise, // Flag
   output logic above_supply_low, // Flag
   output logic above_supply_recover, // Flag
   output logic perm_lock_nv // Stored lock bit
);
   assign above_reset_fall = level >= 3'h1;
   assign above_reset_rise = level >= 3'h2;
   assign above_supply_low = level >= 3'h3;
   assign above_supply_recover = level >= 3'h4;
   // Non-volatile, so it outlives every power cycle
   initial
   begin
      perm_lock_nv = 1'b0;
      forever
      begin
         @(posedge perm_lock_set);
         perm_lock_nv <= 1'b1;
      end
   end
endmodule : pol_supply_model

// [sim/pol_monitor.sv]
`timescale 1ns/10ps
`include "pol_params.svh"
module pol_monitor #(
   parameter int RELEASE_CYC = 10,
   parameter int ENGAGE_CYC = 10,
   parameter int LOCKOUT_REL_CYC = 10,
   parameter logic [`POL_DATA_W-1:0] UNLOCK_CODE = `POL_UNLOCK_CODE
) (
   input wire logic clock, // Clock
   input wire logic rst_b, // Reset
   input wire logic above_reset_fall, // Flag
   input wire logic above_supply_low, // Flag
   input wire logic above_supply_recover, // Flag
   input wire pol_pkg::pol_req_t req, // Request
   input wire logic perm_lock_nv, // Lock bit
   input wire logic internal_reset, // Out
   input wire logic out_enable, // Out
   input wire logic out_force_low, // Out
   input wire logic access_open, // Out
   input wire logic rd_valid // Out
);
   logic [19:0] rst_cnt, low_cnt, rec_cnt;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // Run lengths, so delays are judged in cycles
   always_ff @(posedge clock or negedge rst_b)
      rst_cnt <= !rst_b ? '0 : internal_reset ? rst_cnt + 20'h1 : '0;
   always_ff @(posedge clock or negedge rst_b)
      low_cnt <= !rst_b ? '0 : above_supply_low ? '0 : low_cnt + 20'h1;
   always_ff @(posedge clock or negedge rst_b)
      rec_cnt <= !rst_b ? '0 : above_supply_recover ? rec_cnt + 20'h1 : '0;
   property p_hiz; internal_reset |-> !out_enable; endproperty
   a_hiz: assert property (p_hiz) else $error("hiz");
   property p_fall; !above_reset_fall |=> internal_reset && !access_open;
   endproperty
   a_fall: assert property (p_fall) else $error("fall");
   property p_rel; $fell(internal_reset) |->
      $past(above_supply_recover) && rst_cnt >= RELEASE_CYC; endproperty
   a_rel: assert property (p_rel) else $error("rel");
   property p_eng; $rose(out_force_low) |-> low_cnt >= ENGAGE_CYC - 1;
   endproperty
   a_eng: assert property (p_eng) else $error("eng");
   property p_low; out_force_low |-> !internal_reset; endproperty
   a_low: assert property (p_low) else $error("low");
   property p_rec; $fell(out_force_low) && !internal_reset |->
      rec_cnt >= LOCKOUT_REL_CYC - 1; endproperty
   a_rec: assert property (p_rec) else $error("rec");
   property p_unl; $rose(access_open) |-> $past(req.wr && !perm_lock_nv
      && req.addr == `POL_UNLOCK_ADDR && req.wdata == UNLOCK_CODE);
   endproperty
   a_unl: assert property (p_unl) else $error("unl");
   property p_ref; req.rd && !access_open |=> !rd_valid; endproperty
   a_ref: assert property (p_ref) else $error("ref");
   property p_rd; req.rd && access_open |=> rd_valid; endproperty
   a_rd: assert property (p_rd) else $error("rd");
   cover property ($rose(access_open));
   cover property ($rose(out_force_low));
   cover property ($fell(internal_reset));
endmodule : pol_monitor
bind pol_sequencer pol_monitor #(.RELEASE_CYC(RELEASE_CYC),
   .ENGAGE_CYC(ENGAGE_CYC), .LOCKOUT_REL_CYC(LOCKOUT_REL_CYC),
   .UNLOCK_CODE(UNLOCK_CODE)) i_mon (.clock(clock), .rst_b(rst_b),
   .above_reset_fall(above_reset_fall), .above_supply_low(above_supply_low),
   .above_supply_recover(above_supply_recover), .req(req),
   .perm_lock_nv(perm_lock_nv), .internal_reset(internal_reset),
   .out_enable(out_enable), .out_force_low(out_force_low),
   .access_open(access_open), .rd_valid(rd_valid));

// [sim/power_on_lock_control_tb_top.sv]
`timescale 1ns/10ps
`include "pol_params.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
`define WT(c) for (k = 0; k < 80 && (c) !== 1'b1; k++) tick(1); \
   if (k == 80) begin err_total++; test_done(); end
module power_on_lock_control_tb_top;
   typedef struct {logic [5:0] a; logic [29:0] d;} pol_row_t;
   logic clock = 1'b0, rst_b, v, internal_reset, out_enable, out_force_low;
   logic access_open, rd_valid, perm_lock_set, perm_lock_nv;
   logic rf, rr, sl, sr;
   logic [2:0] level;
   logic [29:0] rd_data, rdat;
   pol_pkg::pol_req_t req;
   pol_pkg::pol_trim_t trim;
   int err_total, checks_done, k;
   // Fine gain first, zero level next, coarse gain last; readback must match the write
   pol_row_t rows [3] = '{'{6'h21, 30'h1a5}, '{6'h22, 30'h0f3},
      '{6'h20, 30'h5}};
   pol_sequencer #(.RELEASE_CYC(10), .ENGAGE_CYC(10), .LOCKOUT_REL_CYC(10),
      .WINDOW_CYC(200)) i_dut (.clock(clock), .rst_b(rst_b),
      .above_reset_rise(rr), .above_reset_fall(rf), .above_supply_low(sl),
      .above_supply_recover(sr), .req(req), .perm_lock_nv(perm_lock_nv),
      .internal_reset(internal_reset), .out_enable(out_enable),
      .out_force_low(out_force_low), .access_open(access_open),
      .rd_valid(rd_valid), .rd_data(rd_data),
      .perm_lock_set(perm_lock_set), .trim(trim));
   pol_supply_model i_sup (.level(level), .perm_lock_set(perm_lock_set),
      .above_reset_fall(rf), .above_reset_rise(rr), .above_supply_low(sl),
      .above_supply_recover(sr), .perm_lock_nv(perm_lock_nv));
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick
   task automatic acc(input logic w, input logic [5:0] a,
      input logic [29:0] d);
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clock);
      v = rd_valid;
      rdat = rd_data;
      req = '0;
      @(negedge clock);
   endtask : acc
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial
   begin
      rst_b = 1'b0;
      level = 3'h0;
      req = '0;
      tick(10);
      rst_b = 1'b1;
      tick(2);
      `CHK("rst", 2'b10, {internal_reset, out_enable})
      `CHK("trim0", {`POL_COARSE_RST, `POL_FINE_RST, `POL_ZERO_RST}, trim)
      acc(0, 6'h21, 30'h0);
      `CHK("lockrd", 1'b0, v)
      acc(1, `POL_UNLOCK_ADDR, `POL_UNLOCK_CODE);
      `CHK("lockwr", 1'b0, access_open)
      level = 3'h2;
      tick(30);
      `CHK("norec", 2'b10, {internal_reset, out_enable})
      level = 3'h4;
      tick(3);
      `CHK("up", 2'b01, {internal_reset, out_enable})
      acc(1, `POL_UNLOCK_ADDR, `POL_UNLOCK_CODE ^ 30'h20000000);
      `CHK("badcode", 1'b0, access_open)
      acc(1, `POL_UNLOCK_ADDR, `POL_UNLOCK_CODE);
      `CHK("unlock", 1'b1, access_open)
      foreach (rows[i])
      begin
         acc(1, rows[i].a, rows[i].d);
         acc(0, rows[i].a, 30'h0);
         `CHK("rd", {1'b1, rows[i].d}, {v, rdat})
      end
      `CHK("trim", {3'h5, 9'h1a5, 9'h0f3}, trim)
      level = 3'h2;
      tick(5);
      level = 3'h4;
      tick(15);
      `CHK("dip", 1'b0, out_force_low)
      level = 3'h2;
      tick(8);
      `CHK("engwait", 1'b0, out_force_low)
      tick(6);
      `CHK("lockout", 1'b1, out_force_low)
      // Above the low threshold but short of recover: lockout must hold
      level = 3'h3;
      tick(15);
      `CHK("lowonly", 1'b1, out_force_low)
      level = 3'h4;
      tick(6);
      `CHK("relwait", 1'b1, out_force_low)
      tick(8);
      `CHK("rel", 2'b01, {out_force_low, out_enable})
      level = 3'h0;
      tick(3);
      `CHK("down", 3'h4, {internal_reset, out_enable, access_open})
      level = 3'h4;
      tick(250);
      acc(1, `POL_UNLOCK_ADDR, `POL_UNLOCK_CODE);
      `CHK("late", 1'b0, access_open)
      level = 3'h0;
      tick(3);
      level = 3'h4;
      `WT(out_enable)
      acc(1, `POL_UNLOCK_ADDR, `POL_UNLOCK_CODE);
      `CHK("reopen", 1'b1, access_open)
      acc(1, 6'h23, 30'h1);
      `CHK("permset", 1'b1, perm_lock_set)
      level = 3'h0;
      tick(3);
      level = 3'h4;
      `WT(out_enable)
      acc(1, `POL_UNLOCK_ADDR, `POL_UNLOCK_CODE);
      `CHK("perm", 1'b0, access_open)
      acc(1, 6'h23, 30'h0);
      acc(0, 6'h23, 30'h0);
      `CHK("permrd", 1'b0, v)
      `CHK("permkeep", 1'b1, perm_lock_set)
      test_done();
   end
endmodule : power_on_lock_control_tb_top
